/* hdl/dac_ctrl_pkg.sv */
// Constants of the octal converter control block: command codes, frame
// fields, control bit positions, reset codes and start-up timing.
// Assumes nothing of its surroundings; shared by the control and shifter.
package dac_ctrl_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int SHIFT_W = 32;
    localparam int WORD_W = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_WRITE_N = 4'h0;
    localparam logic [3:0] CMD_WRITE_ALL = 4'h8;
    localparam logic [3:0] CMD_SPAN_N = 4'h6;
    localparam logic [3:0] CMD_SPAN_ALL = 4'he;
    localparam logic [3:0] CMD_UPD_N = 4'h1;
    localparam logic [3:0] CMD_UPD_ALL = 4'h9;
    localparam logic [3:0] CMD_WR_UPD_N = 4'h3;
    localparam logic [3:0] CMD_WR_N_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_ALL_UPD_ALL = 4'ha;
    localparam logic [3:0] CMD_PD_N = 4'h4;
    localparam logic [3:0] CMD_PD_CHIP = 4'h5;
    localparam logic [3:0] CMD_MUX = 4'hb;
    localparam logic [3:0] CMD_TSEL = 4'hc;
    localparam logic [3:0] CMD_GTOG = 4'hd;
    localparam logic [3:0] CMD_CONFIG = 4'h7;
    localparam logic [3:0] CMD_NOP = 4'hf;

    // ------------------------------------------------------------
    // Data field bit positions
    // ------------------------------------------------------------
    localparam int MUX_EN_BIT = 4;
    localparam int CFG_REF_OFF_BIT = 1;
    localparam int CFG_WRITE_B_BIT = 0;
    localparam int GTOG_B_BIT = 0;
    localparam int SPAN_W = 3;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] STRAP_MID_MASK = 8'hcc;
    localparam logic [1:0] START_WAIT = 2'h3;

endpackage

/* hdl/octal_dac_serial_control.sv */
// Control logic of an eight-channel converter: command execution, input
// and converter registers, update, toggle, clear and over-temperature pins.
// Assumes pins are asynchronous to clock; the serial clock runs only in frames.
//
// Operation
// - Update pin fall, load high: update all
// - Update pin fall in frame: defer
// - Update pin low powers up, blocks power-down
// - Shift only while load select low
// - Load select rise executes held command
// - Sample input bit on serial rising edge
// - Frames of 24 or 32 bits
// - Output is end of 32-bit shifter
// - Echo after 32 edges, on falling edge
// - Output released while load select high
// - Toggle fall loads from register A
// - Toggle rise loads from register B
// - Toggle affects only selected channels
// - Clear low forces strapped code, span
// - Clear also zeroes toggle select, mux and write-B bits
// - Over-temperature pulls flag low
// - Flag released at next load rise
// - Span straps choose power-on span, code
// - Grounded compensation strap disables reference
// - Monitor output released when mux off
// - Command, address, data, MSB first
// - Leading eight bits ignored
// - Update copies A and powers up
// - Two input registers per channel
`timescale 1ns/1ps
module octal_dac_serial_control #(
    parameter int CHAN_N = 8,
    parameter int CODE_W = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sck,
    input wire logic select_and_load_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic async_update_n,
    input wire logic toggle_pin,
    input wire logic clear_n,
    input wire logic over_temperature,
    output logic overtemp_flag_n_out,
    output logic overtemp_flag_n_oe,
    input wire logic [dac_ctrl_pkg::SPAN_W-1:0] span_strap,
    input wire logic reference_compensation_strap,
    output logic [CHAN_N*CODE_W-1:0] dac_code,
    output logic [CHAN_N*dac_ctrl_pkg::SPAN_W-1:0] dac_span,
    output logic [CHAN_N-1:0] channel_powered,
    output logic reference_enable,
    output logic analog_monitor_output_oe,
    output logic [3:0] monitor_select
);

    localparam int SW = dac_ctrl_pkg::SPAN_W;

    initial begin
        if (CHAN_N < 1 || CHAN_N > 16 || CODE_W < 2 || CODE_W > dac_ctrl_pkg::DATA_W) begin
            $error("octal_dac_serial_control: unsupported CHAN_N or CODE_W");
        end
    end

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        logic ld_s1;
        logic ld_s2;
        logic ld_prev;
        logic tg_s1;
        logic tg_s2;
        logic tg_prev;
        logic cl_s1;
        logic cl_s2;
        logic ot_s1;
        logic ot_s2;
        logic rc_s1;
        logic rc_s2;
        logic [SW-1:0] ms_s1;
        logic [SW-1:0] ms_s2;
        logic [1:0] start_cnt;
        logic started;
        logic [CHAN_N-1:0][CODE_W-1:0] in_a;
        logic [CHAN_N-1:0][CODE_W-1:0] in_b;
        logic [CHAN_N-1:0][CODE_W-1:0] dac;
        logic [CHAN_N-1:0][SW-1:0] span_in;
        logic [CHAN_N-1:0][SW-1:0] span_dac;
        logic [CHAN_N-1:0] powered;
        logic [CHAN_N-1:0] tsel;
        logic async_update_n_pend;
        logic mux_en;
        logic [3:0] mux_sel;
        logic ref_off;
        logic write_b;
        logic ot_flag;
        logic sdo_oe;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [dac_ctrl_pkg::SHIFT_W-1:0] shift_word;
    logic cs_lvl;
    logic cs_rise;
    logic ld_fall;
    logic tg_fall;
    logic tg_rise;
    logic clr_ok;
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [dac_ctrl_pkg::DATA_W-1:0] data;
    logic [CODE_W-1:0] code;
    logic [CHAN_N-1:0] wr_mask;
    logic [CHAN_N-1:0] sp_mask;
    logic [CHAN_N-1:0] pd_mask;
    logic [CHAN_N-1:0] upd_mask;
    logic gtog;
    logic tog_a;
    logic tog_b;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [CODE_W-1:0] reset_code(input logic [SW-1:0] strap);
        if (dac_ctrl_pkg::STRAP_MID_MASK[strap]) begin
            return {1'b1, {(CODE_W-1){1'b0}}};
        end
        return '0;
    endfunction

    function automatic logic [CHAN_N-1:0] chan_mask(input logic [3:0] a, input logic all);
        logic [CHAN_N-1:0] m;
        m = '0;
        for (int i = 0; i < CHAN_N; i++) begin
            m[i] = all || (int'(a) == i);
        end
        return m;
    endfunction

    function automatic state_t strap_init(input state_t s, input logic [SW-1:0] strap);
        state_t r;
        r = s;
        for (int i = 0; i < CHAN_N; i++) begin
            r.in_a[i] = reset_code(strap);
            r.in_b[i] = reset_code(strap);
            r.dac[i] = reset_code(strap);
            r.span_in[i] = strap;
            r.span_dac[i] = strap;
        end
        r.powered = '1;
        r.tsel = '0;
        r.async_update_n_pend = 1'b0;
        r.mux_en = 1'b0;
        r.mux_sel = '0;
        r.write_b = 1'b0;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Link side
    // ------------------------------------------------------------
    serial_shifter #(
        .SHIFT_W(dac_ctrl_pkg::SHIFT_W)
    ) u_shifter (
        .sck(sck),
        .rst(rst),
        .select_and_load_n(select_and_load_n),
        .sdi(sdi),
        .shift_word(shift_word),
        .sdo(sdo)
    );

    // ------------------------------------------------------------
    // Control logic
    // ------------------------------------------------------------
    // pin edges seen on clock
    assign cs_lvl = st_r.cs_s2;
    assign cs_rise = st_r.cs_s2 & ~st_r.cs_prev;
    assign ld_fall = ~st_r.ld_s2 & st_r.ld_prev;
    assign tg_fall = ~st_r.tg_s2 & st_r.tg_prev;
    assign tg_rise = st_r.tg_s2 & ~st_r.tg_prev;
    assign clr_ok = st_r.cl_s2 & st_r.started;

    // The word is read only after the select rise has been synchronised;
    // by then no serial edge is accepted, so the bits stand still.
    // last 24 bits are the word
    assign cmd = shift_word[dac_ctrl_pkg::CMD_MSB:dac_ctrl_pkg::CMD_LSB];
    assign addr = shift_word[dac_ctrl_pkg::ADDR_MSB:dac_ctrl_pkg::ADDR_LSB];
    assign data = shift_word[dac_ctrl_pkg::DATA_MSB:0];
    assign code = data[dac_ctrl_pkg::DATA_MSB -: CODE_W];

    always_comb begin
        st_nxt = st_r;
        wr_mask = '0;
        sp_mask = '0;
        pd_mask = '0;
        upd_mask = '0;
        gtog = 1'b0;
        tog_a = 1'b0;
        tog_b = 1'b0;
        st_nxt.cs_s1 = select_and_load_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        st_nxt.cs_prev = st_r.cs_s2;
        st_nxt.ld_s1 = async_update_n;
        st_nxt.ld_s2 = st_r.ld_s1;
        st_nxt.ld_prev = st_r.ld_s2;
        st_nxt.tg_s1 = toggle_pin;
        st_nxt.tg_s2 = st_r.tg_s1;
        st_nxt.tg_prev = st_r.tg_s2;
        st_nxt.cl_s1 = clear_n;
        st_nxt.cl_s2 = st_r.cl_s1;
        st_nxt.ot_s1 = over_temperature;
        st_nxt.ot_s2 = st_r.ot_s1;
        st_nxt.rc_s1 = reference_compensation_strap;
        st_nxt.rc_s2 = st_r.rc_s1;
        st_nxt.ms_s1 = span_strap;
        st_nxt.ms_s2 = st_r.ms_s1;
        st_nxt.sdo_oe = ~cs_lvl;
        st_nxt.ot_flag = st_r.ot_s2 | (st_r.ot_flag & ~cs_rise);
        if (!st_r.started) begin
            st_nxt.start_cnt = st_r.start_cnt + 2'h1;
            if (st_r.start_cnt == dac_ctrl_pkg::START_WAIT) begin
                st_nxt = strap_init(st_nxt, st_r.ms_s2);
                st_nxt.started = 1'b1;
                st_nxt.ref_off = ~st_r.rc_s2;
            end
        end else if (!st_r.cl_s2) begin
            st_nxt = strap_init(st_nxt, st_r.ms_s2);
        end else begin
            if (cs_rise) begin
                unique case (cmd)
                    dac_ctrl_pkg::CMD_WRITE_N: wr_mask = chan_mask(addr, 1'b0);
                    dac_ctrl_pkg::CMD_WRITE_ALL: wr_mask = chan_mask(addr, 1'b1);
                    dac_ctrl_pkg::CMD_SPAN_N: sp_mask = chan_mask(addr, 1'b0);
                    dac_ctrl_pkg::CMD_SPAN_ALL: sp_mask = chan_mask(addr, 1'b1);
                    dac_ctrl_pkg::CMD_UPD_N: upd_mask = chan_mask(addr, 1'b0);
                    dac_ctrl_pkg::CMD_UPD_ALL: upd_mask = chan_mask(addr, 1'b1);
                    dac_ctrl_pkg::CMD_WR_UPD_N: begin
                        wr_mask = chan_mask(addr, 1'b0);
                        upd_mask = chan_mask(addr, 1'b0);
                    end
                    dac_ctrl_pkg::CMD_WR_N_UPD_ALL: begin
                        wr_mask = chan_mask(addr, 1'b0);
                        upd_mask = chan_mask(addr, 1'b1);
                    end
                    dac_ctrl_pkg::CMD_WR_ALL_UPD_ALL: begin
                        wr_mask = chan_mask(addr, 1'b1);
                        upd_mask = chan_mask(addr, 1'b1);
                    end
                    dac_ctrl_pkg::CMD_PD_N: begin
                        if (st_r.ld_s2) begin
                            pd_mask = chan_mask(addr, 1'b0);
                        end
                    end
                    dac_ctrl_pkg::CMD_PD_CHIP: begin
                        if (st_r.ld_s2) begin
                            pd_mask = chan_mask(addr, 1'b1);
                            st_nxt.mux_en = 1'b0;
                            st_nxt.ref_off = 1'b1;
                        end
                    end
                    dac_ctrl_pkg::CMD_MUX: begin
                        st_nxt.mux_en = data[dac_ctrl_pkg::MUX_EN_BIT];
                        st_nxt.mux_sel = data[3:0];
                    end
                    dac_ctrl_pkg::CMD_TSEL: st_nxt.tsel = data[CHAN_N-1:0];
                    dac_ctrl_pkg::CMD_GTOG: gtog = 1'b1;
                    dac_ctrl_pkg::CMD_CONFIG: begin
                        st_nxt.ref_off = data[dac_ctrl_pkg::CFG_REF_OFF_BIT];
                        st_nxt.write_b = data[dac_ctrl_pkg::CFG_WRITE_B_BIT];
                    end
                    dac_ctrl_pkg::CMD_NOP: begin
                    end
                endcase
                if (st_r.async_update_n_pend || ld_fall) begin
                    upd_mask = '1;
                end
                st_nxt.async_update_n_pend = 1'b0;
            end else if (ld_fall) begin
                if (cs_lvl) begin
                    upd_mask = '1;
                end else begin
                    st_nxt.async_update_n_pend = 1'b1;
                end
            end
            // A or B as write target
            for (int i = 0; i < CHAN_N; i++) begin
                if (wr_mask[i] && st_r.write_b) begin
                    st_nxt.in_b[i] = code;
                end else if (wr_mask[i]) begin
                    st_nxt.in_a[i] = code;
                end
                if (sp_mask[i]) begin
                    st_nxt.span_in[i] = data[SW-1:0];
                end
                if (pd_mask[i]) begin
                    st_nxt.powered[i] = 1'b0;
                end
                if (upd_mask[i]) begin
                    st_nxt.dac[i] = st_nxt.in_a[i];
                    st_nxt.span_dac[i] = st_nxt.span_in[i];
                    st_nxt.powered[i] = 1'b1;
                end
            end
            tog_a = tg_fall | (gtog & ~data[dac_ctrl_pkg::GTOG_B_BIT]);
            tog_b = tg_rise | (gtog & data[dac_ctrl_pkg::GTOG_B_BIT]);
            for (int i = 0; i < CHAN_N; i++) begin
                if (st_r.tsel[i] && tog_b) begin
                    st_nxt.dac[i] = st_nxt.in_b[i];
                end else if (st_r.tsel[i] && tog_a) begin
                    st_nxt.dac[i] = st_nxt.in_a[i];
                end
            end
            if (!st_r.ld_s2) begin
                st_nxt.powered = '1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1,
                      ld_s1: 1'b1, ld_s2: 1'b1, ld_prev: 1'b1,
                      cl_s1: 1'b1, cl_s2: 1'b1, sdo_oe: 1'b0, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open-drain flag: the level is always low, only the enable moves.
    assign overtemp_flag_n_out = 1'b0;
    assign overtemp_flag_n_oe = st_r.ot_flag;
    assign sdo_oe = st_r.sdo_oe;
    assign dac_code = st_r.dac;
    assign dac_span = st_r.span_dac;
    assign channel_powered = st_r.powered;
    assign reference_enable = ~st_r.ref_off;
    assign analog_monitor_output_oe = st_r.mux_en;
    assign monitor_select = st_r.mux_sel;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_immediate;
        ld_fall && cs_lvl && st_r.cs_prev && clr_ok && !tg_fall && !tg_rise;
    endsequence

    sequence s_defer;
        ld_fall && !cs_lvl && clr_ok;
    endsequence

    sequence s_release;
        st_r.async_update_n_pend && cs_rise && clr_ok && !tg_fall && !tg_rise;
    endsequence

    a_async_update_n_update_all: assert property (s_immediate |=> st_r.dac == $past(st_r.in_a))
        else $error("update pin did not update all channels");

    a_async_update_n_defer: assert property (s_defer |=> st_r.async_update_n_pend &&
        st_r.dac == $past(st_r.dac))
        else $error("update in frame not deferred");

    a_async_update_n_release: assert property (s_release |=> st_r.dac == st_r.in_a)
        else $error("deferred update lost");

    a_update_power: assert property (!st_r.ld_s2 && clr_ok |=> channel_powered == '1)
        else $error("channels not powered while update pin low");

    a_sdo_release: assert property (cs_lvl [*2] |-> !sdo_oe)
        else $error("output driven outside a frame");

    a_toggle_a: assert property (tg_fall && !cs_rise && !ld_fall && clr_ok &&
        st_r.tsel[0] |=> st_r.dac[0] == $past(st_r.in_a[0]))
        else $error("toggle fall did not load A");

    a_toggle_b: assert property (tg_rise && !cs_rise && !ld_fall && clr_ok &&
        st_r.tsel[0] |=> st_r.dac[0] == $past(st_r.in_b[0]))
        else $error("toggle rise did not load B");

    a_toggle_keep: assert property ((tg_rise || tg_fall) && !cs_rise && !ld_fall &&
        clr_ok && !st_r.tsel[0] |=> $stable(st_r.dac[0]))
        else $error("unselected channel toggled");

    a_clear_force: assert property (st_r.started && !st_r.cl_s2 |=>
        st_r.dac[0] == reset_code($past(st_r.ms_s2)) && st_r.span_dac[0] == $past(st_r.ms_s2))
        else $error("clear did not restore strapped state");

    a_clear_ctrl: assert property (st_r.started && !st_r.cl_s2 |=>
        st_r.tsel == '0 && !st_r.mux_en && !st_r.async_update_n_pend)
        else $error("clear left control bits set");

    a_ot_set: assert property (st_r.ot_s2 |=> overtemp_flag_n_oe)
        else $error("flag not pulled on over-temperature");

    a_ot_release: assert property (overtemp_flag_n_oe && cs_rise && !st_r.ot_s2
        |=> !overtemp_flag_n_oe)
        else $error("flag not released on select rise");

endmodule

/* hdl/serial_shifter.sv */
// Link-side shift register of the serial port, clocked by the serial clock.
// Assumes the serial clock only toggles around frames and that the load
// select is timed to it by the host.
`timescale 1ns/1ps
module serial_shifter #(
    parameter int SHIFT_W = dac_ctrl_pkg::SHIFT_W
) (
    input wire logic sck,
    input wire logic rst,
    input wire logic select_and_load_n,
    input wire logic sdi,
    output logic [SHIFT_W-1:0] shift_word,
    output logic sdo
);

    initial begin
        if (SHIFT_W < dac_ctrl_pkg::WORD_W) begin
            $error("serial_shifter: SHIFT_W too small");
        end
    end

    typedef struct packed {
        logic [SHIFT_W-1:0] shift;
    } link_state_t;

    link_state_t st_r;
    link_state_t st_nxt;
    logic sdo_r;

    // ------------------------------------------------------------
    // Shifting
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (!select_and_load_n) begin
            st_nxt.shift = {st_r.shift[SHIFT_W-2:0], sdi};
        end
    end

    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(negedge sck or posedge rst) begin
        if (rst) begin
            sdo_r <= 1'b0;
        end else begin
            sdo_r <= st_r.shift[SHIFT_W-1];
        end
    end

    assign shift_word = st_r.shift;
    assign sdo = sdo_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shift_hold: assert property (
        @(posedge sck) disable iff (rst)
        select_and_load_n |=> $stable(shift_word))
        else $error("shift register moved outside a frame");

    a_shift_sample: assert property (
        @(posedge sck) disable iff (rst)
        !select_and_load_n |=> shift_word[0] == $past(sdi) &&
            shift_word[SHIFT_W-1:1] == $past(shift_word[SHIFT_W-2:0]))
        else $error("input bit not shifted in");

    a_sdo_echo: assert property (
        @(posedge sck) disable iff (rst)
        !select_and_load_n ##1 !select_and_load_n |->
            sdo == shift_word[SHIFT_W-1])
        else $error("echo output wrong");

endmodule

/* tb/host_model.sv */
// Host side of the serial port, running frames on its own 12 ns link clock.
// Assumes the bench leaves several main clocks between frames.
`timescale 1ns/1ps
module host_model (
    output logic sck,
    output logic select_and_load_n,
    output logic sdi,
    input wire logic sdo
);
    logic [31:0] echo;
    initial begin
        sck = 1'b0;
        select_and_load_n = 1'b1;
        sdi = 1'b0;
    end
    task automatic send(input logic [31:0] w, input int n);
        select_and_load_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #6 echo = {echo[30:0], sdo};
            sck = 1'b1;
            #6 sck = 1'b0;
        end
        #6 select_and_load_n = 1'b1;
        // Idle data line shows no stale bit
        sdi = ~sdi;
    endtask
endmodule

/* tb/tb.sv */
// Self-checking bench of the converter control block.
// Assumes a host model on the serial side; straps tied to mid-scale span 2.
`timescale 1ns/1ps
module tb;
    typedef struct {logic [31:0] w; int n; int ch; logic [15:0] exp;} row_t;
    logic clock = 1'b0, rst = 1'b1, async_update_n = 1'b1, toggle_pin = 1'b0;
    logic clear_n = 1'b1, over_temperature = 1'b0;
    logic sck, sel_n, sdi, sdo, sdo_oe, flag_oe, ref_en, mon_oe;
    logic [127:0] dac_code;
    logic [23:0] dac_span;
    logic [7:0] powered;
    logic [3:0] mon_sel;
    int mismatches = 0, compares = 0, cycles = 0;
    row_t rows[6] = '{'{32'h00311234, 24, 1, 16'h1234}, '{32'hff32abcd, 32, 2, 16'habcd},
        '{32'h00004444, 24, 0, 16'h8000}, '{32'h00100000, 24, 0, 16'h4444},
        '{32'h00a05a5a, 24, 7, 16'h5a5a}, '{32'h00200f0f, 24, 0, 16'h0f0f}};
    always #25 clock = ~clock;
    host_model i_host (.sck(sck), .select_and_load_n(sel_n), .sdi(sdi), .sdo(sdo));
    octal_dac_serial_control i_dut (.clock(clock), .rst(rst), .sck(sck),
        .select_and_load_n(sel_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .async_update_n(async_update_n), .toggle_pin(toggle_pin), .clear_n(clear_n),
        .over_temperature(over_temperature), .overtemp_flag_n_out(),
        .overtemp_flag_n_oe(flag_oe), .span_strap(3'h2),
        .reference_compensation_strap(1'b1), .dac_code(dac_code), .dac_span(dac_span),
        .channel_powered(powered), .reference_enable(ref_en),
        .analog_monitor_output_oe(mon_oe), .monitor_select(mon_sel));
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [31:0] w, input int n);
        @(negedge clock);
        i_host.send(w, n);
        repeat (8) @(negedge clock);
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clock);
    endtask
    function automatic logic [15:0] code(input int ch);
        return dac_code[ch*16 +: 16];
    endfunction
    // Hang guard, far above the few hundred cycles the tests take
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        hold(8);
        rst = 1'b0;
        hold(6);
        check({code(0), 5'h0, dac_span[2:0], powered}, 32'h800002ff);
        check(sdo_oe, 1'b0);
        check({ref_en, mon_oe, mon_sel}, 6'h20);
        foreach (rows[i]) begin
            frame(rows[i].w, rows[i].n);
            check(code(rows[i].ch), rows[i].exp);
        end
        frame(32'hc3f00000, 32);
        frame(32'h0ff00000, 32);
        check(i_host.echo, 32'hc3f00000);
        frame(32'h00003333, 24);
        async_update_n = 1'b0;
        hold(2);
        async_update_n = 1'b1;
        hold(6);
        check(code(0), 16'h3333);
        fork
            frame(32'h00007777, 24);
            begin
                hold(4);
                async_update_n = 1'b0;
                hold(2);
                async_update_n = 1'b1;
            end
        join
        check(code(0), 16'h7777);
        async_update_n = 1'b0;
        frame(32'h00400000, 24);
        check(powered[0], 1'b1);
        async_update_n = 1'b1;
        frame(32'h00400000, 24);
        check(powered[0], 1'b0);
        frame(32'h00700001, 24);
        frame(32'h00032222, 24);
        frame(32'h00700000, 24);
        frame(32'h00031111, 24);
        frame(32'h00c00009, 24);
        toggle_pin = 1'b1;
        hold(25);
        check({code(3), code(4)}, 32'h22225a5a);
        toggle_pin = 1'b0;
        hold(25);
        check(code(3), 16'h1111);
        over_temperature = 1'b1;
        hold(6);
        over_temperature = 1'b0;
        hold(4);
        check(flag_oe, 1'b1);
        frame(32'h00f00000, 24);
        check(flag_oe, 1'b0);
        frame(32'h00b00013, 24);
        check({mon_oe, mon_sel}, 5'h13);
        clear_n = 1'b0;
        hold(6);
        check(code(7), 16'h8000);
        check({mon_oe, mon_sel}, 5'h00);
        clear_n = 1'b1;
        hold(4);
        toggle_pin = 1'b1;
        hold(25);
        check(code(3), 16'h8000);
        complete_run();
    end
endmodule
